/* File: cp_pkg.sv */
// Shared constants, enums and structs of the charge-port mode control
package cp_pkg;

   // APB register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
   localparam logic [7:0] ADDR_IRQ_EN = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_CLR = 8'h10;
   localparam logic [7:0] ADDR_DITHER = 8'h14;

   // Reset values
   localparam logic [1:0] CTRL_RESET = 2'h1;
   localparam logic [3:0] IRQ_EN_RESET = 4'h0;
   localparam logic [3:0] DITHER_RESET = 4'h3;

   // Event bit positions
   localparam int EV_ACTIVE = 0;
   localparam int EV_SHUTDOWN = 1;
   localparam int EV_WARN = 2;
   localparam int EV_THERM_SD = 3;
   localparam int NUM_EV = 4;

   // Sink debounce time and its count at 20 MHz
   localparam int CLK_HZ = 20_000_000;
   localparam int DEBOUNCE_US = 150;
   localparam int DEBOUNCE_CYC = DEBOUNCE_US * (CLK_HZ / 1_000_000);

   // Switching clock defaults, in core cycles
   localparam int SW_PERIOD_CYC = 50;
   localparam int SYNC_TIMEOUT_CYC = 200;

   typedef enum logic [1:0]
   {
      ST_SHUTDOWN = 2'b00,
      ST_STANDBY = 2'b01,
      ST_DEBOUNCE = 2'b10,
      ST_ACTIVE = 2'b11
   } mode_e;

   typedef enum logic [1:0]
   {
      ADV_DEFAULT = 2'b00,
      ADV_1A5 = 2'b01,
      ADV_3A = 2'b10
   } adv_e;

   typedef enum logic [1:0]
   {
      USB_NONE = 2'b00,
      USB_SDP = 2'b01,
      USB_CDP = 2'b10,
      USB_DCP_AUTO = 2'b11
   } usb_e;

   // Comparator and strap levels as seen by the mode machine
   typedef struct packed
   {
      logic enable_ok;
      logic vin_undervoltage_lockout;
      logic vcc_undervoltage_lockout;
      logic sink_cc1;
      logic sink_cc2;
      logic warn;
      logic therm_sd;
      logic sel_a;
      logic sel_b;
   } sense_s;

   localparam int SENSE_W = 9;

endpackage

/* File: cp_sync.sv */
// Two-stage synchroniser bank for comparator and strap levels
`timescale 1ns/1ps

module cp_sync
#(
   parameter int WIDTH = cp_pkg::SENSE_W
)
(
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic RESET_N,
   // Levels
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   typedef struct packed
   {
      logic [WIDTH-1:0] first;
      logic [WIDTH-1:0] second;
   } sync_s;

   sync_s r;
   sync_s next_r;

   always_comb
   begin
      next_r.first = async_in;
      next_r.second = r.first;
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (!RESET_N)
         r <= '0;
      else
         r <= next_r;
   end

   assign sync_out = r.second;

endmodule

/* File: cp_switch_clock.sv */
// Forced-PWM switching clock with dither and external sync lock
`timescale 1ns/1ps

module cp_switch_clock
#(
   parameter int PERIOD = cp_pkg::SW_PERIOD_CYC,
   parameter int TIMEOUT = cp_pkg::SYNC_TIMEOUT_CYC
)
(
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic RESET_N,
   // Control
   input wire logic run,
   input wire logic [3:0] dither_span,
   input wire logic sync_level,
   // Status
   output logic sw_pulse,
   output logic locked
);

   typedef struct packed
   {
      logic [15:0] count;
      logic [15:0] idle;
      logic [3:0] lfsr;
      logic sync_prev;
      logic locked;
      logic pulse;
   } clk_s;

   clk_s r;
   clk_s next_r;
   logic sync_rise;
   logic [15:0] limit;

   assign sync_rise = sync_level && !r.sync_prev;

   always_comb
   begin
      next_r = r;
      next_r.pulse = 1'b0;
      next_r.sync_prev = sync_level;
      // Dither spreads the period only within the programmed span
      limit = 16'(PERIOD) + 16'(r.lfsr & dither_span);
      if (sync_rise)
         next_r.idle = '0;
      else if (r.idle != 16'(TIMEOUT))
         next_r.idle = r.idle + 16'h0001;
      // Lock holds while sync edges keep coming within the timeout
      next_r.locked = (r.idle != 16'(TIMEOUT));
      if (!run)
      begin
         next_r.count = '0;
      end
      else if (r.locked ? sync_rise : (r.count >= limit - 16'h0001))
      begin
         // One pulse every period, never skipped at light load
         next_r.pulse = 1'b1;
         next_r.count = '0;
         next_r.lfsr = {r.lfsr[2:0], r.lfsr[3] ^ r.lfsr[2]};
      end
      else
      begin
         next_r.count = r.count + 16'h0001;
      end
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (!RESET_N)
      begin
         r <= '0;
         r.lfsr <= 4'h1;
         // No sync edge seen yet, so start unlocked
         r.idle <= 16'(TIMEOUT);
      end
      else
         r <= next_r;
   end

   assign sw_pulse = r.pulse;
   assign locked = r.locked;

endmodule

/* File: charge_port_mode_control.sv */
// Mode, advertisement and thermal control of a Type-C charge port
// How it works
// - Warning level at 3 A advertisement drops advertisement to 1.5 A.
// - Warning level raises overtemp warning flag; fault stays low.
// - Shutdown level stops buck and drives load-switch gate low.
// - During thermistor shutdown the warning stays set, fault stays low.
// - Enable low forces shutdown with regulator off, whatever else.
// - Either supply undervoltage turns the regulator off.
// - Enabled without sink: standby, buck off, until Rd seen.
// - Active only with enable, both supplies good and a sink present.
// - Active buck runs forced PWM, constant frequency, no skipped pulses.
// - Active switching frequency is dithered within a narrow band.
// - Switching clock locks to a valid external sync clock.
// - Mode-select pins watched continuously; changes apply without restart.
// - 10 is 1.5 A SDP, 11 is 3 A CDP, 01 is 3 A DCP; here 01 gives DCP only with HAS_THERMISTOR set, else no mode.
// - Sink detection is debounced before the buck turns on.
// - Enable is sampled only once the input supply is above lockout.
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps

module charge_port_mode_control
#(
   parameter bit HAS_THERMISTOR = 1'b1,
   parameter int DEBOUNCE_CYCLES = cp_pkg::DEBOUNCE_CYC
)
(
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic RESET_N,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Comparator levels
   input wire logic ENABLE_ABOVE_THRESHOLD,
   input wire logic VIN_UNDERVOLTAGE_LOCKOUT,
   input wire logic VCC_UNDERVOLTAGE_LOCKOUT,
   input wire logic SINK_DETECT_CC1,
   input wire logic SINK_DETECT_CC2,
   input wire logic THERMISTOR_SENSE_WARN,
   input wire logic THERMAL_SHUTDOWN_LEVEL,
   // Mode straps and sync clock
   input wire logic MODE_SELECT_A,
   input wire logic MODE_SELECT_B,
   input wire logic FREQ_SET_SYNC_INPUT,
   // Outputs
   output logic BUCK_ENABLE,
   output logic BUCK_SWITCH_PULSE,
   output logic FORCED_PULSE_WIDTH_MODULATION,
   output logic LOAD_SWITCH_GATE_DRIVE,
   output logic OVERTEMP_WARNING_FLAG,
   output logic FAULT,
   output logic [1:0] CURRENT_ADVERTISEMENT,
   output logic [1:0] USB_MODE,
   output logic IRQ
);

   ////////////////////////////////////////////////////////////////////////
   // Types and state

   typedef struct packed
   {
      cp_pkg::mode_e mode;
      logic [23:0] debounce;
      logic enable_seen;
      logic [1:0] ctrl;
      logic [3:0] irq_stat;
      logic [3:0] irq_en;
      logic [3:0] dither;
      logic [31:0] rdata;
      logic slverr;
      logic buck;
      logic gate;
      logic warn;
      cp_pkg::adv_e adv;
      cp_pkg::usb_e usb;
   } core_s;

   core_s r;
   core_s next_r;
   cp_pkg::sense_s s;
   cp_pkg::sense_s raw;
   logic sw_pulse;
   logic sync_locked;
   logic [3:0] events;
   logic sink;
   logic supplies_ok;
   logic run_ok;
   logic apb_access;
   logic apb_write;

   ////////////////////////////////////////////////////////////////////////
   // Input synchronisation

   assign raw = '{enable_ok: ENABLE_ABOVE_THRESHOLD,
                  vin_undervoltage_lockout: VIN_UNDERVOLTAGE_LOCKOUT,
                  vcc_undervoltage_lockout: VCC_UNDERVOLTAGE_LOCKOUT,
                  sink_cc1: SINK_DETECT_CC1,
                  sink_cc2: SINK_DETECT_CC2,
                  warn: THERMISTOR_SENSE_WARN,
                  therm_sd: THERMAL_SHUTDOWN_LEVEL,
                  sel_a: MODE_SELECT_A,
                  sel_b: MODE_SELECT_B};

   cp_sync #(.WIDTH(cp_pkg::SENSE_W)) u_sync
   (
      .CORE_CLK(CORE_CLK),
      .RESET_N(RESET_N),
      .async_in(raw),
      .sync_out(s)
   );

   cp_switch_clock u_swclk
   (
      .CORE_CLK(CORE_CLK),
      .RESET_N(RESET_N),
      .run(r.buck),
      .dither_span(r.dither),
      .sync_level(FREQ_SET_SYNC_INPUT),
      .sw_pulse(sw_pulse),
      .locked(sync_locked)
   );

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   // Mode straps to USB mode; reserved codes give no mode
   function automatic cp_pkg::usb_e decode_usb(input logic a, input logic b);
      if (a && b)
         decode_usb = cp_pkg::USB_CDP;
      else if (a)
         decode_usb = cp_pkg::USB_SDP;
      else if (b && HAS_THERMISTOR)
         decode_usb = cp_pkg::USB_DCP_AUTO;
      else
         decode_usb = cp_pkg::USB_NONE;
   endfunction

   function automatic cp_pkg::adv_e decode_adv(input cp_pkg::usb_e u);
      case (u)
         cp_pkg::USB_SDP: decode_adv = cp_pkg::ADV_1A5;
         cp_pkg::USB_CDP: decode_adv = cp_pkg::ADV_3A;
         cp_pkg::USB_DCP_AUTO: decode_adv = cp_pkg::ADV_3A;
         default: decode_adv = cp_pkg::ADV_DEFAULT;
      endcase
   endfunction

   assign sink = s.sink_cc1 || s.sink_cc2;
   assign supplies_ok = !s.vin_undervoltage_lockout && !s.vcc_undervoltage_lockout;
   // Software can hold the port off through the control register
   assign run_ok = s.enable_ok && r.enable_seen && supplies_ok && r.ctrl[0];
   assign apb_access = PSEL && PENABLE;
   assign apb_write = apb_access && PWRITE;

   ////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb
   begin
      next_r = r;
      events = '0;

      // Enable only counts once input supply has cleared lockout
      if (s.vin_undervoltage_lockout || !s.enable_ok)
         next_r.enable_seen = 1'b0;
      else
         next_r.enable_seen = 1'b1;

      case (r.mode)
         cp_pkg::ST_SHUTDOWN:
         begin
            if (run_ok)
               next_r.mode = cp_pkg::ST_STANDBY;
         end
         cp_pkg::ST_STANDBY:
         begin
            next_r.debounce = '0;
            if (!run_ok)
               next_r.mode = cp_pkg::ST_SHUTDOWN;
            else if (sink)
               next_r.mode = cp_pkg::ST_DEBOUNCE;
         end
         cp_pkg::ST_DEBOUNCE:
         begin
            if (!run_ok)
               next_r.mode = cp_pkg::ST_SHUTDOWN;
            else if (!sink)
               next_r.mode = cp_pkg::ST_STANDBY;
            else if (r.debounce >= 24'(DEBOUNCE_CYCLES - 1))
               next_r.mode = cp_pkg::ST_ACTIVE;
            else
               next_r.debounce = r.debounce + 24'h000001;
         end
         cp_pkg::ST_ACTIVE:
         begin
            if (!run_ok)
               next_r.mode = cp_pkg::ST_SHUTDOWN;
            else if (!sink)
               next_r.mode = cp_pkg::ST_STANDBY;
         end
         default:
            next_r.mode = cp_pkg::ST_SHUTDOWN;
      endcase

      // Buck and gate follow the next mode, gated by the thermal shutdown level
      next_r.buck = (next_r.mode == cp_pkg::ST_ACTIVE)
                    && !(HAS_THERMISTOR && s.therm_sd);
      next_r.gate = next_r.buck;
      next_r.warn = HAS_THERMISTOR && (s.warn || s.therm_sd);

      next_r.usb = decode_usb(s.sel_a, s.sel_b);
      next_r.adv = decode_adv(next_r.usb);
      if (next_r.warn && next_r.adv == cp_pkg::ADV_3A)
         next_r.adv = cp_pkg::ADV_1A5;
      if (next_r.mode != cp_pkg::ST_ACTIVE)
         next_r.adv = cp_pkg::ADV_DEFAULT;

      // Event sources for the interrupt status
      events[cp_pkg::EV_ACTIVE] = next_r.buck && !r.buck;
      events[cp_pkg::EV_SHUTDOWN] = (next_r.mode == cp_pkg::ST_SHUTDOWN)
                                    && (r.mode != cp_pkg::ST_SHUTDOWN);
      events[cp_pkg::EV_WARN] = next_r.warn && !r.warn;
      events[cp_pkg::EV_THERM_SD] = HAS_THERMISTOR && s.therm_sd
                                    && r.buck;

      ////////////////////////////////////////////////////////////////////
      // APB registers, zero wait states

      next_r.slverr = 1'b0;
      next_r.rdata = '0;
      if (PSEL && !PENABLE && !PWRITE)
      begin
         if (PADDR == cp_pkg::ADDR_CTRL)
            next_r.rdata = {30'h0, r.ctrl};
         else if (PADDR == cp_pkg::ADDR_STATUS)
            next_r.rdata = {20'h0, sync_locked, r.usb, r.adv, r.warn,
                            r.gate, r.buck, 2'h0, r.mode};
         else if (PADDR == cp_pkg::ADDR_IRQ_STAT)
            next_r.rdata = {28'h0, r.irq_stat};
         else if (PADDR == cp_pkg::ADDR_IRQ_EN)
            next_r.rdata = {28'h0, r.irq_en};
         else if (PADDR == cp_pkg::ADDR_DITHER)
            next_r.rdata = {28'h0, r.dither};
         else if (PADDR != cp_pkg::ADDR_IRQ_CLR)
            next_r.slverr = 1'b1;
      end
      else if (PSEL && !PENABLE)
      begin
         if (PADDR != cp_pkg::ADDR_CTRL && PADDR != cp_pkg::ADDR_IRQ_EN
             && PADDR != cp_pkg::ADDR_IRQ_CLR && PADDR != cp_pkg::ADDR_DITHER)
            next_r.slverr = 1'b1;
      end
      else if (apb_access)
      begin
         next_r.rdata = r.rdata;
         next_r.slverr = r.slverr;
      end

      if (apb_write && PADDR == cp_pkg::ADDR_CTRL)
         next_r.ctrl = PWDATA[1:0];
      if (apb_write && PADDR == cp_pkg::ADDR_IRQ_EN)
         next_r.irq_en = PWDATA[3:0];
      if (apb_write && PADDR == cp_pkg::ADDR_DITHER)
         next_r.dither = PWDATA[3:0];
      // A clear never hides an event of the same cycle
      if (apb_write && PADDR == cp_pkg::ADDR_IRQ_CLR)
         next_r.irq_stat = (r.irq_stat & ~PWDATA[3:0]) | events;
      else
         next_r.irq_stat = r.irq_stat | events;
   end

   ////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge CORE_CLK)
   begin
      if (!RESET_N)
      begin
         r <= '0;
         r.mode <= cp_pkg::ST_SHUTDOWN;
         r.ctrl <= cp_pkg::CTRL_RESET;
         r.irq_en <= cp_pkg::IRQ_EN_RESET;
         r.dither <= cp_pkg::DITHER_RESET;
      end
      else
         r <= next_r;
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   assign PRDATA = r.rdata;
   assign PREADY = 1'b1;
   assign PSLVERR = r.slverr && apb_access;
   assign BUCK_ENABLE = r.buck;
   assign BUCK_SWITCH_PULSE = sw_pulse;
   assign FORCED_PULSE_WIDTH_MODULATION = r.buck;
   assign LOAD_SWITCH_GATE_DRIVE = r.gate;
   assign OVERTEMP_WARNING_FLAG = r.warn;
   assign FAULT = 1'b0;
   assign CURRENT_ADVERTISEMENT = r.adv;
   assign USB_MODE = r.usb;
   assign IRQ = |(r.irq_stat & r.irq_en);

endmodule

/* File: cpmc_props.sv */
// Checker of mode, thermal and switching behaviour at the top ports
`timescale 1ns/1ps

module cpmc_props
#(
   parameter int DEBOUNCE_CYCLES = 4
)
(
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic RESET_N,
   // Levels in
   input wire logic ENABLE_ABOVE_THRESHOLD,
   input wire logic VIN_UNDERVOLTAGE_LOCKOUT,
   input wire logic VCC_UNDERVOLTAGE_LOCKOUT,
   input wire logic SINK_DETECT_CC1,
   input wire logic SINK_DETECT_CC2,
   input wire logic THERMISTOR_SENSE_WARN,
   input wire logic THERMAL_SHUTDOWN_LEVEL,
   input wire logic MODE_SELECT_A,
   input wire logic MODE_SELECT_B,
   // Outputs watched
   input wire logic BUCK_ENABLE,
   input wire logic BUCK_SWITCH_PULSE,
   input wire logic FORCED_PULSE_WIDTH_MODULATION,
   input wire logic LOAD_SWITCH_GATE_DRIVE,
   input wire logic OVERTEMP_WARNING_FLAG,
   input wire logic FAULT,
   input wire logic [1:0] CURRENT_ADVERTISEMENT,
   input wire logic [1:0] USB_MODE
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RESET_N);
   logic sink;
   logic hot;
   logic [15:0] sink_run;
   logic [7:0] gap;
   assign sink = SINK_DETECT_CC1 || SINK_DETECT_CC2;
   assign hot = THERMISTOR_SENSE_WARN || THERMAL_SHUTDOWN_LEVEL;
   ///////////////////////////////////////////
   // Sink age and cycles since last switching pulse
   always_ff @(posedge CORE_CLK)
   begin
      if (!RESET_N || !sink)
         sink_run <= 16'h0000;
      else if (sink_run != 16'hFFFF)
         sink_run <= sink_run + 16'h0001;
      if (!RESET_N || !BUCK_ENABLE || BUCK_SWITCH_PULSE)
         gap <= 8'h00;
      else if (gap != 8'hFF)
         gap <= gap + 8'h01;
   end
   fault_stays_low_a: assert property (FAULT == 1'b0)
      else $error("fault output raised");
   warn_sets_flag_a: assert property (hot [*4]
      |-> OVERTEMP_WARNING_FLAG) else $error("warning flag missing");
   warn_clears_a: assert property (!hot [*4]
      |-> !OVERTEMP_WARNING_FLAG) else $error("warning flag stuck");
   therm_stop_a: assert property (THERMAL_SHUTDOWN_LEVEL [*4]
      |-> !BUCK_ENABLE && !LOAD_SWITCH_GATE_DRIVE) else $error("buck on hot");
   enable_off_a: assert property (!ENABLE_ABOVE_THRESHOLD [*5]
      |-> !BUCK_ENABLE && !LOAD_SWITCH_GATE_DRIVE) else $error("buck on");
   undervoltage_lockout_off_a: assert property ((VIN_UNDERVOLTAGE_LOCKOUT
      || VCC_UNDERVOLTAGE_LOCKOUT) [*5] |-> !BUCK_ENABLE)
      else $error("buck on in lockout");
   standby_off_a: assert property (!sink [*5] |-> !BUCK_ENABLE)
      else $error("buck on without sink");
   entry_debounce_a: assert property ($rose(BUCK_ENABLE)
      |-> sink_run > DEBOUNCE_CYCLES && ENABLE_ABOVE_THRESHOLD)
      else $error("buck on too early");
   forced_pulse_width_modulation_tracks_a: assert property (FORCED_PULSE_WIDTH_MODULATION
      == BUCK_ENABLE) else $error("forced mode differs from buck");
   no_skip_a: assert property (gap < 8'hD2)
      else $error("switching pulse skipped");
   adv_derate_a: assert property (OVERTEMP_WARNING_FLAG
      |-> CURRENT_ADVERTISEMENT != 2'h2) else $error("3 A while warm");
   strap_sdp_a: assert property (
      (MODE_SELECT_A && !MODE_SELECT_B) [*4] |-> USB_MODE == 2'h1)
      else $error("strap not followed");
endmodule

bind charge_port_mode_control cpmc_props
   #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) checker_i
(
   .CORE_CLK(CORE_CLK), .RESET_N(RESET_N),
   .ENABLE_ABOVE_THRESHOLD(ENABLE_ABOVE_THRESHOLD),
   .VIN_UNDERVOLTAGE_LOCKOUT(VIN_UNDERVOLTAGE_LOCKOUT),
   .VCC_UNDERVOLTAGE_LOCKOUT(VCC_UNDERVOLTAGE_LOCKOUT),
   .SINK_DETECT_CC1(SINK_DETECT_CC1), .SINK_DETECT_CC2(SINK_DETECT_CC2),
   .THERMISTOR_SENSE_WARN(THERMISTOR_SENSE_WARN),
   .THERMAL_SHUTDOWN_LEVEL(THERMAL_SHUTDOWN_LEVEL),
   .MODE_SELECT_A(MODE_SELECT_A), .MODE_SELECT_B(MODE_SELECT_B),
   .BUCK_ENABLE(BUCK_ENABLE), .BUCK_SWITCH_PULSE(BUCK_SWITCH_PULSE),
   .FORCED_PULSE_WIDTH_MODULATION(FORCED_PULSE_WIDTH_MODULATION),
   .LOAD_SWITCH_GATE_DRIVE(LOAD_SWITCH_GATE_DRIVE),
   .OVERTEMP_WARNING_FLAG(OVERTEMP_WARNING_FLAG), .FAULT(FAULT),
   .CURRENT_ADVERTISEMENT(CURRENT_ADVERTISEMENT), .USB_MODE(USB_MODE)
);

/* File: cp_sink_model.sv */
// Attached sink and external sync clock facing the charge port
`timescale 1ns/1ps

module cp_sink_model
(
   // Clock
   input wire logic clk,
   // Scenario control
   input wire logic attach,
   input wire logic flip,
   input wire logic sync_on,
   // Far-side levels
   output logic cc1,
   output logic cc2,
   output logic sync_clk
);
   logic [4:0] tick;
   // Rd shows on one line only, chosen by plug orientation
   assign cc1 = attach && !flip;
   assign cc2 = attach && flip;
   initial
   begin
      tick = 5'h00;
      sync_clk = 1'b0;
   end
   ///////////////////////////////////////////
   // Sync of 60 core cycles; held low when off, never free running
   always @(posedge clk)
   begin
      tick <= (!sync_on || tick == 5'h1D) ? 5'h00 : tick + 5'h01;
      if (!sync_on)
         sync_clk <= 1'b0;
      else if (tick == 5'h1D)
         sync_clk <= !sync_clk;
   end
endmodule

/* File: tb_top.sv */
// Self-checking bench of the charge-port mode control
`timescale 1ns/1ps

module tb_top;
   localparam int deb_cycles = 4;
   logic clk, rst_n, psel, pen, pwr, pready, pslverr, en, vin, vcc, err;
   logic warn, sd, sel_a, sel_b, attach, flip, sync_on, cc1, cc2, sync;
   logic buck, pulse, forced_pulse_width_modulation, gate, flag, fault, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0] adv, usb;
   int fails, tests_run, n;

   charge_port_mode_control #(.DEBOUNCE_CYCLES(deb_cycles)) DUT
   (
      .CORE_CLK(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(pen),
      .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .ENABLE_ABOVE_THRESHOLD(en),
      .VIN_UNDERVOLTAGE_LOCKOUT(vin), .VCC_UNDERVOLTAGE_LOCKOUT(vcc),
      .SINK_DETECT_CC1(cc1), .SINK_DETECT_CC2(cc2),
      .THERMISTOR_SENSE_WARN(warn), .THERMAL_SHUTDOWN_LEVEL(sd),
      .MODE_SELECT_A(sel_a), .MODE_SELECT_B(sel_b),
      .FREQ_SET_SYNC_INPUT(sync), .BUCK_ENABLE(buck),
      .BUCK_SWITCH_PULSE(pulse), .FORCED_PULSE_WIDTH_MODULATION(forced_pulse_width_modulation),
      .LOAD_SWITCH_GATE_DRIVE(gate), .OVERTEMP_WARNING_FLAG(flag),
      .FAULT(fault), .CURRENT_ADVERTISEMENT(adv), .USB_MODE(usb), .IRQ(irq)
   );
   cp_sink_model far_end
   (
      .clk(clk), .attach(attach), .flip(flip), .sync_on(sync_on),
      .cc1(cc1), .cc2(cc2), .sync_clk(sync)
   );

   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   ///////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         fails++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge clk);
   endtask

   task automatic cnt(input int k);
      n = 0;
      repeat (k)
      begin
         @(posedge clk);
         n += int'(pulse === 1'b1);
      end
   endtask

   // Idle cycle after each transfer keeps psel from two updates per step
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do
      begin
         @(posedge clk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask

   task automatic close_out;
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial
   begin
      tick(10000);
      fails++;
      close_out;
   end
   ///////////////////////////////////////////
   initial
   begin
      {psel, pen, pwr, paddr, pwdata} = '0;
      {en, vin, vcc, warn, sd, attach, flip, sync_on} = 8'h80;
      {sel_a, sel_b} = 2'b11;
      {rst_n, fails, tests_run} = '0;
      tick(16);
      rst_n <= 1'b1;
      tick(2);
      apb(1'b0, cp_pkg::ADDR_CTRL, 32'h0);
      chk(rd, 32'(cp_pkg::CTRL_RESET));
      apb(1'b0, cp_pkg::ADDR_IRQ_EN, 32'h0);
      chk(rd, 32'(cp_pkg::IRQ_EN_RESET));
      apb(1'b0, cp_pkg::ADDR_DITHER, 32'h0);
      chk(rd, 32'(cp_pkg::DITHER_RESET));
      apb(1'b0, 8'h40, 32'h0);
      chk(err, 1'b1);
      apb(1'b1, cp_pkg::ADDR_STATUS, 32'hFFFFFFFF);
      chk(err, 1'b1);
      tick(8);
      apb(1'b0, cp_pkg::ADDR_STATUS, 32'h0);
      chk({rd[1:0], buck}, 3'b010);
      attach <= 1'b1;
      tick(20);
      chk({buck, gate, usb, adv, irq}, 7'b1110100);
      apb(1'b0, cp_pkg::ADDR_IRQ_STAT, 32'h0);
      chk(rd[0], 1'b1);
      apb(1'b1, cp_pkg::ADDR_IRQ_EN, 32'h1);
      chk(irq, 1'b1);
      apb(1'b1, cp_pkg::ADDR_IRQ_CLR, 32'h1);
      chk(irq, 1'b0);
      for (int c = 1; c < 4; c++)
      begin
         {sel_a, sel_b} <= 2'(c);
         tick(6);
         chk(usb, (c == 2) ? 2'h1 : (c == 1) ? 2'h3 : 2'h2);
         chk(adv, (c == 2) ? 2'h1 : 2'h2);
      end
      cnt(400);
      chk(n >= 7 && n <= 8, 1'b1);
      sync_on <= 1'b1;
      tick(200);
      cnt(600);
      chk(n >= 9 && n <= 10, 1'b1);
      apb(1'b0, cp_pkg::ADDR_STATUS, 32'h0);
      chk(rd[11], 1'b1);
      sync_on <= 1'b0;
      warn <= 1'b1;
      tick(6);
      chk({flag, fault, adv}, 4'b1001);
      sd <= 1'b1;
      tick(6);
      chk({buck, gate, flag, fault}, 4'b0010);
      {warn, sd} <= 2'b00;
      tick(6);
      chk({buck, gate, flag, adv}, 5'b11010);
      apb(1'b0, cp_pkg::ADDR_IRQ_STAT, 32'h0);
      chk(rd[3:0], 4'hD);
      for (int k = 0; k < 3; k++)
      begin
         {en, vin, vcc} <= 3'b100 ^ (3'b100 >> k);
         tick(6);
         chk({buck, gate}, 2'b00);
         {en, vin, vcc} <= 3'b100;
         tick(20);
         chk(buck, 1'b1);
      end
      attach <= 1'b0;
      tick(6);
      chk(buck, 1'b0);
      {flip, attach} <= 2'b11;
      tick(2);
      attach <= 1'b0;
      tick(12);
      chk(buck, 1'b0);
      attach <= 1'b1;
      tick(20);
      chk(buck, 1'b1);
      close_out;
   end
endmodule
